/* File: phb_pkg.sv */
// shared constants, types and carriers for the host bridge behaviour block
// How it works
// - root port local events and errors leave as MSI memory writes, not wires
// - every MSI write on the AXI manager port carries one reserved manager ID
// - MSI writes delay an ordinary memory write on the same manager port by one turn at most
// - optional downgrade: timed-out MMIO read returns all ones with OKAY response
// - every endpoint translation request is passed to the translation unit
// - a translation fault is answered with successful completion with data
// - that faulted completion clears read and write permission bits of data
// - unaligned host accesses with strobes become TLPs with dword address and BEs clipped to that dword
// - 1, 2 and 4 byte config accesses reach root port or downstream correctly
package phb_pkg;
    localparam int ID_W = 8;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;
    localparam int ATS_W = 64;
    localparam logic [ID_W-1:0] MSI_AXI_ID = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] CPL_STATUS_SC = 3'h0;
    localparam int ATS_R_BIT = 0;
    localparam int ATS_W_BIT = 1;
    localparam int CFG_BUS_LSB = 20;
    localparam logic CTO_DOWNGRADE_RST = 1'b0;
    localparam logic [DATA_W-1:0] ALL_ONES = 32'hFFFFFFFF;

    typedef enum logic [1:0] {
        PHB_CPL_OK = 2'b00,
        PHB_CPL_TIMEOUT = 2'b01,
        PHB_CPL_ERR = 2'b10
    } phb_cpl_st_e;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] strb;
        logic [1:0] size;
        logic write;
        logic cfg;
    } phb_host_req_s;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] first_be;
        logic write;
        logic cfg;
        logic to_root_port;
    } phb_tlp_req_s;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [DATA_W-1:0] data;
        phb_cpl_st_e status;
        logic write;
    } phb_cpl_s;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [DATA_W-1:0] rdata;
        logic [1:0] resp;
        logic write;
    } phb_host_rsp_s;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } phb_axi_wr_s;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic [1:0] resp;
    } phb_axi_b_s;

    typedef struct packed {
        logic [7:0] tag;
        logic [15:0] req_id;
        logic [ATS_W-1:0] addr;
    } phb_ats_req_s;

    typedef struct packed {
        logic [7:0] tag;
        logic [15:0] req_id;
        logic fault;
        logic [ATS_W-1:0] data;
    } phb_ats_rsp_s;

    typedef struct packed {
        logic [7:0] tag;
        logic [15:0] req_id;
        logic has_data;
        logic [2:0] status;
        logic [ATS_W-1:0] data;
    } phb_ats_cpl_s;

    typedef enum logic {
        PHB_MSI_IDLE = 1'b0,
        PHB_MSI_SEND = 1'b1
    } phb_msi_st_e;
endpackage

/* File: phb_msi_gen.sv */
// turns root port event pulses into MSI write requests
`timescale 1ns/1ps
`default_nettype none
module phb_msi_gen #(
    parameter int NUM_EVT = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [NUM_EVT-1:0] evt,
    input wire logic [phb_pkg::ADDR_W-1:0] msi_addr,
    input wire logic [phb_pkg::DATA_W-1:0] msi_data_base,
    output logic [NUM_EVT-1:0] pending,
    output logic msi_valid,
    input wire logic msi_ready,
    output phb_pkg::phb_axi_wr_s msi_wr
);
    phb_pkg::phb_msi_st_e st_q, st_d;
    logic [NUM_EVT-1:0] pend_q, pend_d;
    logic [NUM_EVT-1:0] clr;
    phb_pkg::phb_axi_wr_s wr_q, wr_d;
    logic [phb_pkg::DATA_W-1:0] idx;
    logic found;

    always_comb
    begin
        idx = '0;
        found = 1'b0;
        for (int i = NUM_EVT - 1; i >= 0; i--)
        begin
            if (pend_q[i])
            begin
                idx = phb_pkg::DATA_W'(i);
                found = 1'b1;
            end
        end
        st_d = st_q;
        wr_d = wr_q;
        clr = '0;
        unique case (st_q)
            phb_pkg::PHB_MSI_IDLE:
            begin
                if (found)
                begin
                    // lowest pending bit, the same one the index search picked
                    clr = pend_q & (~pend_q + NUM_EVT'(1));
                    wr_d.id = phb_pkg::MSI_AXI_ID;
                    wr_d.addr = msi_addr;
                    wr_d.data = msi_data_base + idx;
                    wr_d.strb = '1;
                    st_d = phb_pkg::PHB_MSI_SEND;
                end
            end
            phb_pkg::PHB_MSI_SEND:
            begin
                if (msi_ready)
                    st_d = phb_pkg::PHB_MSI_IDLE;
            end
        endcase
        // a new event in the clearing cycle stays pending
        pend_d = (pend_q & ~clr) | evt;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_q <= phb_pkg::PHB_MSI_IDLE;
            pend_q <= '0;
            wr_q <= '0;
        end
        else
        begin
            st_q <= st_d;
            pend_q <= pend_d;
            wr_q <= wr_d;
        end
    end

    assign pending = pend_q;
    assign msi_valid = (st_q == phb_pkg::PHB_MSI_SEND);
    assign msi_wr = wr_q;
endmodule // phb_msi_gen
`default_nettype wire

/* File: phb_bridge.sv */
// host bridge behaviour: MSI merge, request conversion, completions and ATS
`timescale 1ns/1ps
`default_nettype none
module phb_bridge #(
    parameter int NUM_EVT = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cto_downgrade_en,
    input wire logic [7:0] root_bus_num,
    input wire logic [NUM_EVT-1:0] rp_event,
    input wire logic [phb_pkg::ADDR_W-1:0] msi_addr,
    input wire logic [phb_pkg::DATA_W-1:0] msi_data_base,
    output logic [NUM_EVT-1:0] msi_pending,
    input wire logic host_req_valid,
    output logic host_req_ready,
    input wire phb_pkg::phb_host_req_s host_req,
    output logic tlp_valid,
    input wire logic tlp_ready,
    output phb_pkg::phb_tlp_req_s tlp,
    input wire logic cpl_valid,
    output logic cpl_ready,
    input wire phb_pkg::phb_cpl_s cpl,
    output logic host_rsp_valid,
    input wire logic host_rsp_ready,
    output phb_pkg::phb_host_rsp_s host_rsp,
    input wire logic dma_wr_valid,
    output logic dma_wr_ready,
    input wire phb_pkg::phb_axi_wr_s dma_wr,
    output logic axi_wr_valid,
    input wire logic axi_wr_ready,
    output phb_pkg::phb_axi_wr_s axi_wr,
    input wire logic axi_b_valid,
    output logic axi_b_ready,
    input wire phb_pkg::phb_axi_b_s axi_b,
    output logic dma_b_valid,
    input wire logic dma_b_ready,
    output phb_pkg::phb_axi_b_s dma_b,
    input wire logic ats_req_valid,
    output logic ats_req_ready,
    input wire phb_pkg::phb_ats_req_s ats_req,
    output logic xlat_req_valid,
    input wire logic xlat_req_ready,
    output phb_pkg::phb_ats_req_s xlat_req,
    input wire logic xlat_rsp_valid,
    output logic xlat_rsp_ready,
    input wire phb_pkg::phb_ats_rsp_s xlat_rsp,
    output logic ats_cpl_valid,
    input wire logic ats_cpl_ready,
    output phb_pkg::phb_ats_cpl_s ats_cpl
);
    // interrupt message source
    logic msi_valid;
    logic msi_ready;
    phb_pkg::phb_axi_wr_s msi_wr;

    phb_msi_gen #(
        .NUM_EVT(NUM_EVT)
    ) u_msi (
        .mclk(mclk),
        .rst(rst),
        .evt(rp_event),
        .msi_addr(msi_addr),
        .msi_data_base(msi_data_base),
        .pending(msi_pending),
        .msi_valid(msi_valid),
        .msi_ready(msi_ready),
        .msi_wr(msi_wr)
    );

    // option register, off through reset
    logic cto_q, cto_d;

    // manager write port: alternating priority between dma and msi
    logic aw_vld_q, aw_vld_d;
    phb_pkg::phb_axi_wr_s aw_q, aw_d;
    logic prio_msi_q, prio_msi_d;
    logic aw_free;
    logic pick_msi;

    // write response steering
    logic b_vld_q, b_vld_d;
    phb_pkg::phb_axi_b_s b_q, b_d;
    logic b_is_msi;

    // host request conversion
    logic t_vld_q, t_vld_d;
    phb_pkg::phb_tlp_req_s t_q, t_d;
    logic [phb_pkg::STRB_W-1:0] rd_be;
    logic [phb_pkg::STRB_W-1:0] lane_mask;

    // host response
    logic r_vld_q, r_vld_d;
    phb_pkg::phb_host_rsp_s r_q, r_d;

    // translation forward and completion
    logic x_vld_q, x_vld_d;
    phb_pkg::phb_ats_req_s x_q, x_d;
    logic c_vld_q, c_vld_d;
    phb_pkg::phb_ats_cpl_s c_q, c_d;

    always_comb
    begin
        cto_d = cto_downgrade_en;
    end

    assign aw_free = !aw_vld_q || axi_wr_ready;
    // msi has its own ID and its own turn, so ordinary writes always progress
    assign pick_msi = msi_valid && (prio_msi_q || !dma_wr_valid);
    assign msi_ready = aw_free && pick_msi;
    assign dma_wr_ready = aw_free && !pick_msi;

    always_comb
    begin
        aw_vld_d = aw_vld_q;
        aw_d = aw_q;
        prio_msi_d = prio_msi_q;
        if (aw_free)
        begin
            aw_vld_d = msi_valid || dma_wr_valid;
            if (pick_msi)
            begin
                aw_d = msi_wr;
                prio_msi_d = 1'b0;
            end
            else if (dma_wr_valid)
            begin
                aw_d = dma_wr;
                prio_msi_d = 1'b1;
            end
        end
    end

    // responses to interrupt writes are swallowed here
    assign b_is_msi = (axi_b.id == phb_pkg::MSI_AXI_ID);
    assign axi_b_ready = b_is_msi || !b_vld_q || dma_b_ready;

    always_comb
    begin
        b_vld_d = b_vld_q && !dma_b_ready;
        b_d = b_q;
        if (axi_b_valid && !b_is_msi && (!b_vld_q || dma_b_ready))
        begin
            b_vld_d = 1'b1;
            b_d = axi_b;
        end
    end

    // byte enables of a read from address offset and transfer size
    always_comb
    begin
        unique case (host_req.size)
            2'h0: lane_mask = 4'h1;
            2'h1: lane_mask = 4'h3;
            default: lane_mask = 4'hF;
        endcase
        rd_be = phb_pkg::STRB_W'(lane_mask << host_req.addr[1:0]);
    end

    assign host_req_ready = !t_vld_q || tlp_ready;

    always_comb
    begin
        t_vld_d = t_vld_q && !tlp_ready;
        t_d = t_q;
        if (host_req_valid && host_req_ready)
        begin
            t_vld_d = 1'b1;
            t_d.id = host_req.id;
            t_d.addr = {host_req.addr[phb_pkg::ADDR_W-1:2], 2'b00};
            t_d.data = host_req.wdata;
            // write lanes follow the strobes, clipped to the addressed bytes
            t_d.first_be = host_req.write ? (host_req.strb & rd_be) : rd_be;
            t_d.write = host_req.write;
            t_d.cfg = host_req.cfg;
            t_d.to_root_port = host_req.cfg &&
                (host_req.addr[phb_pkg::CFG_BUS_LSB +: 8] == root_bus_num);
        end
    end

    assign cpl_ready = !r_vld_q || host_rsp_ready;

    always_comb
    begin
        r_vld_d = r_vld_q && !host_rsp_ready;
        r_d = r_q;
        if (cpl_valid && cpl_ready)
        begin
            r_vld_d = 1'b1;
            r_d.id = cpl.id;
            r_d.write = cpl.write;
            r_d.rdata = cpl.data;
            r_d.resp = phb_pkg::RESP_OKAY;
            if (cpl.status == phb_pkg::PHB_CPL_TIMEOUT && cto_q && !cpl.write)
            begin
                r_d.rdata = phb_pkg::ALL_ONES;
            end
            else if (cpl.status != phb_pkg::PHB_CPL_OK)
            begin
                r_d.resp = phb_pkg::RESP_SLVERR;
            end
        end
    end

    assign ats_req_ready = !x_vld_q || xlat_req_ready;

    always_comb
    begin
        x_vld_d = x_vld_q && !xlat_req_ready;
        x_d = x_q;
        if (ats_req_valid && ats_req_ready)
        begin
            x_vld_d = 1'b1;
            x_d = ats_req;
        end
    end

    assign xlat_rsp_ready = !c_vld_q || ats_cpl_ready;

    always_comb
    begin
        c_vld_d = c_vld_q && !ats_cpl_ready;
        c_d = c_q;
        if (xlat_rsp_valid && xlat_rsp_ready)
        begin
            c_vld_d = 1'b1;
            c_d.tag = xlat_rsp.tag;
            c_d.req_id = xlat_rsp.req_id;
            c_d.has_data = 1'b1;
            c_d.status = phb_pkg::CPL_STATUS_SC;
            c_d.data = xlat_rsp.data;
            if (xlat_rsp.fault)
            begin
                c_d.data[phb_pkg::ATS_R_BIT] = 1'b0;
                c_d.data[phb_pkg::ATS_W_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cto_q <= phb_pkg::CTO_DOWNGRADE_RST;
            aw_vld_q <= 1'b0;
            aw_q <= '0;
            prio_msi_q <= 1'b0;
            b_vld_q <= 1'b0;
            b_q <= '0;
            t_vld_q <= 1'b0;
            t_q <= '0;
            r_vld_q <= 1'b0;
            r_q <= '0;
            x_vld_q <= 1'b0;
            x_q <= '0;
            c_vld_q <= 1'b0;
            c_q <= '0;
        end
        else
        begin
            cto_q <= cto_d;
            aw_vld_q <= aw_vld_d;
            aw_q <= aw_d;
            prio_msi_q <= prio_msi_d;
            b_vld_q <= b_vld_d;
            b_q <= b_d;
            t_vld_q <= t_vld_d;
            t_q <= t_d;
            r_vld_q <= r_vld_d;
            r_q <= r_d;
            x_vld_q <= x_vld_d;
            x_q <= x_d;
            c_vld_q <= c_vld_d;
            c_q <= c_d;
        end
    end

    assign axi_wr_valid = aw_vld_q;
    assign axi_wr = aw_q;
    assign dma_b_valid = b_vld_q;
    assign dma_b = b_q;
    assign tlp_valid = t_vld_q;
    assign tlp = t_q;
    assign host_rsp_valid = r_vld_q;
    assign host_rsp = r_q;
    assign xlat_req_valid = x_vld_q;
    assign xlat_req = x_q;
    assign ats_cpl_valid = c_vld_q;
    assign ats_cpl = c_q;
endmodule // phb_bridge
`default_nettype wire

/* File: phb_bridge_chk.sv */
// port checker for the host bridge
`timescale 1ns/1ps
`default_nettype none
module phb_bridge_chk #(
    parameter int NUM_EVT = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cto_downgrade_en,
    input wire logic [NUM_EVT-1:0] rp_event,
    input wire logic [31:0] msi_addr,
    input wire logic [NUM_EVT-1:0] msi_pending,
    input wire logic host_req_valid,
    input wire logic host_req_ready,
    input wire phb_pkg::phb_host_req_s host_req,
    input wire logic tlp_valid,
    input wire phb_pkg::phb_tlp_req_s tlp,
    input wire logic cpl_valid,
    input wire logic cpl_ready,
    input wire phb_pkg::phb_cpl_s cpl,
    input wire logic host_rsp_valid,
    input wire phb_pkg::phb_host_rsp_s host_rsp,
    input wire logic dma_wr_valid,
    input wire logic dma_wr_ready,
    input wire phb_pkg::phb_axi_wr_s dma_wr,
    input wire logic axi_wr_valid,
    input wire phb_pkg::phb_axi_wr_s axi_wr,
    input wire logic xlat_rsp_valid,
    input wire logic xlat_rsp_ready,
    input wire phb_pkg::phb_ats_rsp_s xlat_rsp,
    input wire logic ats_cpl_valid,
    input wire phb_pkg::phb_ats_cpl_s ats_cpl
);
    logic [7:0] lane_mask;
    logic [3:0] be_exp;
    always_comb
    begin
        lane_mask = ((8'h01 << (8'h01 << host_req.size)) - 8'h01) << host_req.addr[1:0];
        be_exp = lane_mask[3:0] & (host_req.write ? host_req.strb : 4'hF);
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_EVT_PEND: assert property (|rp_event
        |=> (msi_pending & $past(rp_event)) == $past(rp_event)) else $error("event lost");
    AST_MSI_OUT: assert property ($rose(|msi_pending)
        |-> ##[1:40] axi_wr_valid && axi_wr.id == phb_pkg::MSI_AXI_ID) else $error("no MSI");
    AST_MSI_ID: assert property (axi_wr_valid && axi_wr.id == phb_pkg::MSI_AXI_ID
        |-> axi_wr.addr == msi_addr && axi_wr.strb == 4'hF) else $error("bad MSI write");
    AST_DMA_PASS: assert property (dma_wr_valid && dma_wr_ready
        |=> axi_wr_valid && axi_wr == $past(dma_wr)) else $error("write altered");
    AST_DMA_WAIT: assert property (dma_wr_valid |-> ##[0:40] dma_wr_ready)
        else $error("write blocked");
    AST_TLP_ADDR: assert property (host_req_valid && host_req_ready |=> tlp_valid
        && tlp.addr == {$past(host_req.addr[31:2]), 2'h0} && tlp.first_be == $past(be_exp))
        else $error("bad TLP address");
    AST_CTO_ONES: assert property (cpl_valid && cpl_ready && !cpl.write
        && cpl.status == phb_pkg::PHB_CPL_TIMEOUT && cto_downgrade_en && $past(cto_downgrade_en)
        |=> host_rsp_valid && host_rsp.resp == phb_pkg::RESP_OKAY
        && host_rsp.rdata == phb_pkg::ALL_ONES) else $error("timeout kept");
    AST_ATS_FAULT: assert property (xlat_rsp_valid && xlat_rsp_ready && xlat_rsp.fault
        |=> ats_cpl_valid && ats_cpl.has_data && ats_cpl.status == phb_pkg::CPL_STATUS_SC
        && ats_cpl.data[1:0] == 2'h0) else $error("bad fault reply");
    COV_ONES: cover property (cpl_valid && cpl_ready && cto_downgrade_en
        && cpl.status == phb_pkg::PHB_CPL_TIMEOUT);
    COV_FAULT: cover property (xlat_rsp_valid && xlat_rsp_ready && xlat_rsp.fault);
    COV_RACE: cover property (axi_wr_valid && axi_wr.id == phb_pkg::MSI_AXI_ID && dma_wr_valid);
endmodule // phb_bridge_chk
bind phb_bridge phb_bridge_chk #(.NUM_EVT(NUM_EVT)) u_chk (.*);
`default_nettype wire

/* File: phb_rp_model.sv */
// root port model: takes TLPs, answers each with one completion
`timescale 1ns/1ps
`default_nettype none
module phb_rp_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic slow,
    input wire phb_pkg::phb_cpl_st_e cpl_mode,
    input wire logic tlp_valid,
    output logic tlp_ready,
    input wire phb_pkg::phb_tlp_req_s tlp,
    output logic cpl_valid,
    input wire logic cpl_ready,
    output phb_pkg::phb_cpl_s cpl
);
    logic busy_q;
    logic stall_q;
    phb_pkg::phb_cpl_s cpl_q;
    assign tlp_ready = !busy_q && !(slow && stall_q);
    assign cpl_valid = busy_q;
    // idle bus shows inverted data, never the last answer
    assign cpl = busy_q ? cpl_q : ~cpl_q;
    always_ff @(posedge mclk)
    begin
        stall_q <= !rst && !stall_q;
        if (rst)
            busy_q <= 1'b0;
        else if (busy_q)
            busy_q <= !cpl_ready;
        else if (tlp_valid && tlp_ready)
        begin
            busy_q <= 1'b1;
            cpl_q <= {tlp.id, tlp.addr ^ 32'h5A5AC3C3, cpl_mode, tlp.write};
        end
    end
endmodule // phb_rp_model
`default_nettype wire

/* File: phb_bridge_tb_top.sv */
// self-checking bench for the host bridge
`timescale 1ns/1ps
`default_nettype none
module phb_bridge_tb_top;
    logic mclk = 1'b0, rst = 1'b1, cto_downgrade_en = 1'b0, slow = 1'b0;
    logic host_req_valid = 1'b0, dma_wr_valid = 1'b0, axi_b_valid = 1'b0;
    logic ats_req_valid = 1'b0, xlat_rsp_valid = 1'b0, host_rsp_ready = 1'b0;
    logic axi_wr_ready = 1'b0, dma_b_ready = 1'b0, xlat_req_ready = 1'b0, ats_cpl_ready = 1'b0;
    logic [7:0] root_bus_num = 8'h3C, rp_event = 8'h0, msi_pending;
    logic [31:0] msi_addr = 32'h0800F040, msi_data_base = 32'h00004A20;
    phb_pkg::phb_cpl_st_e cpl_mode = phb_pkg::PHB_CPL_OK;
    phb_pkg::phb_host_req_s host_req = '0;
    phb_pkg::phb_axi_wr_s dma_wr = '0, axi_wr, dma_exp[8], beats[$];
    phb_pkg::phb_axi_b_s axi_b = '0, dma_b, bq[$];
    phb_pkg::phb_ats_req_s ats_req = '0, xlat_req;
    phb_pkg::phb_ats_rsp_s xlat_rsp = '0;
    logic host_req_ready, tlp_valid, tlp_ready, cpl_valid, cpl_ready, host_rsp_valid;
    logic dma_wr_ready, axi_wr_valid, axi_b_ready, dma_b_valid, ats_req_ready;
    logic xlat_req_valid, xlat_rsp_ready, ats_cpl_valid;
    phb_pkg::phb_tlp_req_s tlp;
    phb_pkg::phb_cpl_s cpl;
    phb_pkg::phb_host_rsp_s host_rsp;
    phb_pkg::phb_ats_cpl_s ats_cpl;
    int failures = 0, comparisons = 0;
    logic [31:0] seed = 32'hFD198C62, rb;

    phb_bridge #(.NUM_EVT(8)) dut (.*);
    phb_rp_model u_rp (.*);

    always #2 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [3:0] be_of(input phb_pkg::phb_host_req_s r);
        logic [7:0] m;
        m = ((8'h01 << (8'h01 << r.size)) - 8'h01) << r.addr[1:0];
        return m[3:0] & (r.write ? r.strb : 4'hF);
    endfunction

    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic host_op(input phb_pkg::phb_host_req_s r, input phb_pkg::phb_cpl_st_e st);
        phb_pkg::phb_tlp_req_s t;
        phb_pkg::phb_host_rsp_s h;
        logic ok;
        logic [31:0] a;
        cpl_mode = st;
        host_req = r;
        host_req_valid = 1'b1;
        @(posedge mclk iff host_req_ready);
        #1 host_req_valid = 1'b0;
        @(posedge mclk iff (tlp_valid && tlp_ready));
        t = tlp;
        @(posedge mclk iff (host_rsp_valid && host_rsp_ready));
        h = host_rsp;
        #1;
        a = {r.addr[31:2], 2'h0};
        ok = st == phb_pkg::PHB_CPL_OK;
        ok = ok || (st == phb_pkg::PHB_CPL_TIMEOUT && cto_downgrade_en && !r.write);
        check({t.addr, t.first_be}, {a, be_of(r)});
        check({t.cfg, t.to_root_port}, {r.cfg, r.cfg && r.addr[27:20] == root_bus_num});
        check({t.id, t.data, t.write}, {r.id, r.wdata, r.write});
        check({h.id, h.write}, {r.id, r.write});
        check(h.resp, ok ? phb_pkg::RESP_OKAY : phb_pkg::RESP_SLVERR);
        if (ok && !r.write)
            check(h.rdata, st == phb_pkg::PHB_CPL_OK ? a ^ 32'h5A5AC3C3 : phb_pkg::ALL_ONES);
    endtask

    // readies wander so every stage sees stalls
    always @(posedge mclk)
    begin
        rb = rnd();
        host_rsp_ready <= |rb[1:0];
        xlat_req_ready <= |rb[3:2];
        ats_cpl_ready <= |rb[5:4];
        dma_b_ready <= |rb[7:6];
        axi_wr_ready <= |rb[9:8];
        slow <= rb[10];
        if (axi_wr_valid && axi_wr_ready)
            beats.push_back(axi_wr);
        if (dma_b_valid && dma_b_ready)
            bq.push_back(dma_b);
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        failures++;
        complete_run();
    end

    initial
    begin
        phb_pkg::phb_host_req_s r;
        phb_pkg::phb_ats_rsp_s x;
        logic [7:0] seen;
        int nd;
        int nm;
        repeat (16) @(posedge mclk);
        #1 rst = 1'b0;
        for (int k = 0; k < 48; k++)
        begin
            r = 80'({rnd(), rnd(), rnd()});
            if (r.size == 2'h3)
                r.size = 2'h2;
            if (k[0])
                r.addr[27:20] = root_bus_num;
            if (k == 0)
                r.addr = 32'h00001003;
            if (k == 24)
                cto_downgrade_en = 1'b1;
            // first timed-out read with the downgrade option on
            if (k == 25)
                r.write = 1'b0;
            host_op(r, phb_pkg::phb_cpl_st_e'(k % 3));
        end
        for (int k = 0; k < 12; k++)
        begin
            ats_req = 88'({rnd(), rnd(), rnd()});
            ats_req_valid = 1'b1;
            @(posedge mclk iff ats_req_ready);
            #1 ats_req_valid = 1'b0;
            @(posedge mclk iff (xlat_req_valid && xlat_req_ready));
            check(xlat_req, ats_req);
            #1 x = 89'({rnd(), rnd(), rnd()});
            x.fault = k[0];
            xlat_rsp = x;
            xlat_rsp_valid = 1'b1;
            @(posedge mclk iff xlat_rsp_ready);
            #1 xlat_rsp_valid = 1'b0;
            @(posedge mclk iff (ats_cpl_valid && ats_cpl_ready));
            check(ats_cpl, {x.tag, x.req_id, 4'h8, x.fault ? x.data & 64'hFFFFFFFFFFFFFFFC : x.data});
            #1;
        end
        fork
            begin
                rp_event = 8'hA5;
                #4 rp_event = 8'h00;
                #24 rp_event = 8'h5A;
                #4 rp_event = 8'h00;
            end
            begin
                for (int k = 0; k < 8; k++)
                begin
                    dma_exp[k] = {8'(k), rnd(), rnd(), 4'(k + 1)};
                    dma_wr = dma_exp[k];
                    dma_wr_valid = 1'b1;
                    @(posedge mclk iff dma_wr_ready);
                    #1;
                end
                dma_wr_valid = 1'b0;
            end
        join
        repeat (60) @(posedge mclk);
        #1 seen = 8'h00;
        nd = 0;
        nm = 0;
        foreach (beats[i])
        begin
            if (beats[i].id == phb_pkg::MSI_AXI_ID)
            begin
                check({beats[i].addr, beats[i].strb}, {msi_addr, 4'hF});
                seen = seen | (8'h01 << (beats[i].data - msi_data_base));
                nm++;
            end
            else
            begin
                check(beats[i], dma_exp[nd]);
                nd++;
            end
        end
        check({seen, 8'(nm), 8'(nd)}, {8'hFF, 8'h08, 8'h08});
        foreach (beats[i])
        begin
            axi_b = {beats[i].id, phb_pkg::RESP_OKAY};
            axi_b_valid = 1'b1;
            @(posedge mclk iff axi_b_ready);
            #1;
        end
        axi_b_valid = 1'b0;
        repeat (20) @(posedge mclk);
        check(bq.size(), 8);
        foreach (bq[i])
            check(bq[i], {8'(i), phb_pkg::RESP_OKAY});
        complete_run();
    end
endmodule // phb_bridge_tb_top
`default_nettype wire
